// >>> hw/clock_control_pkg.sv
// Purpose: constants shared by the clock control block and its divider
// Assumes: 50 MHz core clock, AXI4-Lite register access, 32-bit data
// Notes:   every offset, field position, reset value and count lives here
package clock_control_pkg;

    // bus geometry
    localparam int              ADDR_W        = 8;
    localparam int              DATA_W        = 32;

    // register byte offsets
    localparam logic [7:0]      CC_OFS        = 8'h00;
    localparam logic [7:0]      TA_OFS        = 8'h04;
    localparam logic [7:0]      STAT_OFS      = 8'h08;
    localparam logic [7:0]      OPT_OFS       = 8'h0C;

    // clock control fields
    localparam int              CC_STRETCH_BIT = 0;
    localparam int              CC_T0_BIT      = 3;
    localparam logic [7:0]      CC_WMASK       = 8'h39;
    localparam logic [7:0]      CC_RESET       = 8'h39;

    // status fields
    localparam int              ST_WIN_BIT     = 0;
    localparam int              ST_OPT_BIT     = 1;
    localparam int              ST_REFUSED_BIT = 2;
    localparam int              ST_BUSY_BIT    = 3;
    localparam int              ST_EFF_LSB     = 4;

    // option register
    localparam int              OPT_TWELVE_BIT = 0;
    localparam logic            OPT_RESET      = 1'h0;

    // timed-access unlock
    localparam logic [7:0]      TA_KEY1        = 8'hAA;
    localparam logic [7:0]      TA_KEY2        = 8'h55;
    localparam logic [3:0]      TA_WINDOW_CYC  = 4'h4;

    // divider phases: 12 clocks per full period
    localparam logic [3:0]      PHASE_MID      = 4'h5;
    localparam logic [3:0]      PHASE_LAST     = 4'hB;

    // machine cycle lengths in core clocks
    localparam logic [4:0]      MC_TURBO_CYC   = 5'h06;
    localparam logic [4:0]      MC_STD_CYC     = 5'h0C;

    // bus responses
    localparam logic [1:0]      RESP_OKAY      = 2'h0;
    localparam logic [1:0]      RESP_SLVERR    = 2'h2;

    // transfer sequencer states
    typedef enum logic {XF_IDLE, XF_STROBE} xfer_state_e;

endpackage

// >>> hw/timebase_divider.sv
// Purpose: free-running divide-by-6 and divide-by-12 enable pulses
// Assumes: single core clock, synchronised active-low reset
// Notes:   both pulses share one counter so they stay phase aligned
`timescale 1ns/100ps
module timebase_divider
    import clock_control_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    output logic [3:0]      o_phase,
    output logic            o_tick6,
    output logic            o_tick12
);

    logic [3:0] phase_d;    // next phase
    logic       tick6_d;    // next divide-by-6 pulse
    logic       tick12_d;   // next divide-by-12 pulse

    // phase walks 0..11; pulses mark the half and full period
    always_comb begin
        phase_d  = (o_phase == PHASE_LAST) ? 4'h0 : o_phase + 4'h1;
        tick6_d  = (o_phase == PHASE_MID) || (o_phase == PHASE_LAST);
        tick12_d = (o_phase == PHASE_LAST);
    end

    // registered so that every pulse is glitch free
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase  <= 4'h0;
            o_tick6  <= 1'b0;
            o_tick12 <= 1'b0;
        end else begin
            o_phase  <= phase_d;
            o_tick6  <= tick6_d;
            o_tick12 <= tick12_d;
        end
    end

endmodule // timebase_divider

// >>> hw/clock_control.sv
// Purpose: clock control register, timer time-base and transfer stretch
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes:   clock control writes need the timed-access unlock first
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module clock_control
    import clock_control_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    // write address channel
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    // write data channel
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    // write response channel
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    output logic [1:0]             o_bresp,
    // read address channel
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    // read data channel
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [1:0]             o_rresp,
    // timer count enables
    output logic                   o_timer0_tick,
    output logic                   o_timer1_tick,
    output logic                   o_timer2_tick,
    // external data transfer
    input  wire logic              i_xfer_req,
    output logic                   o_xfer_strobe,
    output logic                   o_xfer_done
);

    // reset release: asserted at once, removed through two flops
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // shared divider
    logic [3:0] phase;      // divider phase, for checking only
    logic       tick6;      // divide-by-6 enable
    logic       tick12;     // divide-by-12 enable

    timebase_divider u_div (
        .i_mclk   (i_mclk),
        .i_rst_n  (rst_n),
        .o_phase  (phase),
        .o_tick6  (tick6),
        .o_tick12 (tick12)
    );

    // register and bus state
    logic [7:0]        cc_q, cc_d;           // clock control contents
    logic              opt_q, opt_d;         // twelve-clock option
    logic              stage_q, stage_d;     // first key seen
    logic [3:0]        win_q, win_d;         // unlock cycles left
    logic              refused_q, refused_d; // locked write seen
    logic              aw_have_q, aw_have_d; // write address held
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic              w_have_q, w_have_d;   // write data held
    logic [7:0]        w_data_q, w_data_d;   // only byte lane 0 used
    logic              w_lane_q, w_lane_d;   // byte lane 0 enabled
    logic              awready_d, wready_d, bvalid_d, arready_d;
    logic              rvalid_d;
    logic [1:0]        bresp_d, rresp_d;
    logic [DATA_W-1:0] rdata_d;
    logic              do_write;             // both halves present
    logic              win_open;             // unlock window live
    logic [2:0]        eff12;                // timer runs at /12
    logic              xf_busy;              // transfer in progress

    assign win_open = (win_q != 4'h0);

    // per-timer effective select: option forces divide-by-12
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_eff
            assign eff12[g] = opt_q | cc_q[CC_T0_BIT+g];
        end
    endgenerate

    // bus slave, register writes, unlock sequence, read mux
    always_comb begin
        cc_d      = cc_q;
        opt_d     = opt_q;
        stage_d   = stage_q;
        refused_d = refused_q;
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = o_bvalid;
        bresp_d   = o_bresp;
        rvalid_d  = o_rvalid;
        rresp_d   = o_rresp;
        rdata_d   = o_rdata;
        // window counts down on its own
        win_d     = win_open ? win_q - 4'h1 : 4'h0;
        do_write  = aw_have_q && w_have_q && !o_bvalid;
        // address and data are taken in either order
        if (i_awvalid && o_awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            w_have_d = 1'b1;
            w_data_d = i_wdata[7:0];
            w_lane_d = i_wstrb[0];
        end
        if (o_bvalid && i_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            unique case (aw_addr_q)
                CC_OFS: begin
                    if (!w_lane_q) begin
                        // no byte enabled: nothing to store
                    end else if (win_open) begin
                        // reserved bits never stored
                        cc_d  = w_data_q & CC_WMASK;
                        win_d = 4'h0; // one write per unlock
                    end else begin
                        refused_d = 1'b1; // locked write ignored
                    end
                end
                TA_OFS: begin
                    // keys must arrive back to back on this port
                    if (w_lane_q && w_data_q == TA_KEY1) begin
                        stage_d = 1'b1;
                    end else if (w_lane_q && stage_q
                                 && w_data_q == TA_KEY2) begin
                        stage_d = 1'b0;
                        win_d   = TA_WINDOW_CYC;
                    end else begin
                        stage_d = 1'b0;
                    end
                end
                STAT_OFS: begin
                    // write one clears; a new refusal still wins
                    if (w_lane_q && w_data_q[ST_REFUSED_BIT]) begin
                        refused_d = 1'b0;
                    end
                end
                OPT_OFS: begin
                    if (w_lane_q) begin
                        opt_d = w_data_q[OPT_TWELVE_BIT];
                    end
                end
                default: begin
                    bresp_d = RESP_SLVERR; // unmapped address
                end
            endcase
            // any other write breaks a half-done key pair
            if (aw_addr_q != TA_OFS) begin
                stage_d = 1'b0;
            end
        end
        // read answer; clock control needs no unlock
        if (o_rvalid && i_rready) begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = '0;
            unique case (i_araddr)
                CC_OFS: begin
                    rdata_d[7:0] = cc_q;
                end
                TA_OFS: begin
                    rdata_d = '0; // keys are write only
                end
                STAT_OFS: begin
                    rdata_d[ST_WIN_BIT]     = win_open;
                    rdata_d[ST_OPT_BIT]     = opt_q;
                    rdata_d[ST_REFUSED_BIT] = refused_q;
                    rdata_d[ST_BUSY_BIT]    = xf_busy;
                    rdata_d[ST_EFF_LSB+:3]  = eff12;
                end
                OPT_OFS: begin
                    rdata_d[OPT_TWELVE_BIT] = opt_q;
                end
                default: begin
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        // readies from next state so that outputs stay registered
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // register the bus and control state
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cc_q      <= CC_RESET; // stretch of one machine cycle
            opt_q     <= OPT_RESET;
            stage_q   <= 1'b0;
            win_q     <= 4'h0;
            refused_q <= 1'b0;
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rresp   <= RESP_OKAY;
            o_rdata   <= '0;
        end else begin
            cc_q      <= cc_d;
            opt_q     <= opt_d;
            stage_q   <= stage_d;
            win_q     <= win_d;
            refused_q <= refused_d;
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            o_awready <= awready_d;
            o_wready  <= wready_d;
            o_bvalid  <= bvalid_d;
            o_bresp   <= bresp_d;
            o_arready <= arready_d;
            o_rvalid  <= rvalid_d;
            o_rresp   <= rresp_d;
            o_rdata   <= rdata_d;
        end
    end

    // timer enables: pick the divider output per timer
    logic [2:0] tick_d;

    always_comb begin
        tick_d = (eff12 & {3{tick12}}) | (~eff12 & {3{tick6}});
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_timer0_tick <= 1'b0;
            o_timer1_tick <= 1'b0;
            o_timer2_tick <= 1'b0;
        end else begin
            o_timer0_tick <= tick_d[0];
            o_timer1_tick <= tick_d[1];
            o_timer2_tick <= tick_d[2];
        end
    end

    // transfer sequencer: strobe lasts one machine cycle, plus one
    // more when stretched; settings are caught at the start so a
    // mid-transfer register write cannot cut a strobe short
    xfer_state_e xf_q, xf_d;
    logic [4:0]  cnt_q, cnt_d;         // cycles left in strobe
    logic [4:0]  xfer_len_q, xfer_len_d;
    logic [4:0]  mc_len;               // machine cycle in clocks
    logic [4:0]  len_now;              // length if started now
    logic        strobe_d, done_d;

    assign xf_busy = (xf_q == XF_STROBE);
    assign mc_len  = opt_q ? MC_STD_CYC : MC_TURBO_CYC;
    assign len_now = cc_q[CC_STRETCH_BIT] ? {mc_len[3:0], 1'b0}
                                          : mc_len;

    always_comb begin
        xf_d       = xf_q;
        cnt_d      = cnt_q;
        xfer_len_d = xfer_len_q;
        strobe_d   = o_xfer_strobe;
        done_d     = 1'b0;
        unique case (xf_q)
            XF_IDLE: begin
                // requests while busy are not queued
                if (i_xfer_req) begin
                    xf_d       = XF_STROBE;
                    cnt_d      = len_now - 5'h01;
                    xfer_len_d = len_now;
                    strobe_d   = 1'b1;
                end
            end
            XF_STROBE: begin
                if (cnt_q == 5'h00) begin
                    xf_d     = XF_IDLE;
                    strobe_d = 1'b0;
                    done_d   = 1'b1;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            xf_q          <= XF_IDLE;
            cnt_q         <= 5'h00;
            xfer_len_q    <= 5'h00;
            o_xfer_strobe <= 1'b0;
            o_xfer_done   <= 1'b0;
        end else begin
            xf_q          <= xf_d;
            cnt_q         <= cnt_d;
            xfer_len_q    <= xfer_len_d;
            o_xfer_strobe <= strobe_d;
            o_xfer_done   <= done_d;
        end
    end

    // helper: strobe length counter for checking
    logic [4:0] strb_len_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            strb_len_q <= 5'h00;
        end else begin
            strb_len_q <= o_xfer_strobe ? strb_len_q + 5'h01 : 5'h00;
        end
    end

    timer0_rate_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_timer0_tick |-> ($past(phase, 2) == PHASE_LAST) ||
            ($past(phase, 2) == PHASE_MID && !$past(eff12[0])))
        else $error("timer0 tick at wrong divider phase");

    option_override_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        ($past(opt_q) && (o_timer1_tick || o_timer2_tick))
            |-> $past(phase, 2) == PHASE_LAST)
        else $error("timer ran fast with twelve-clock option");

    strobe_length_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        $fell(o_xfer_strobe) |-> strb_len_q == xfer_len_q && o_xfer_done)
        else $error("transfer strobe length wrong");

    fast_access_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        (xf_q == XF_IDLE && i_xfer_req && !cc_q[CC_STRETCH_BIT])
            |=> xfer_len_q == $past(mc_len))
        else $error("unstretched transfer not one machine cycle");

    free_read_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        (i_arvalid && o_arready && i_araddr == CC_OFS)
            |=> o_rvalid && o_rdata[7:0] == $past(cc_q))
        else $error("clock control read did not return contents");

    locked_write_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        (do_write && aw_addr_q == CC_OFS && !win_open && w_lane_q)
            |=> $stable(cc_q) && refused_q)
        else $error("locked write changed clock control");

    timer2_rate_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_timer2_tick |-> ($past(phase, 2) == PHASE_LAST) ||
            ($past(phase, 2) == PHASE_MID && !$past(eff12[2])))
        else $error("timer2 tick at wrong divider phase");

    reserved_zero_a: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        (i_arvalid && o_arready && i_araddr == CC_OFS)
            |=> (o_rdata & ~{24'h000000, CC_WMASK}) == '0)
        else $error("reserved clock control bits read nonzero");

endmodule // clock_control

// >>> verif/tb_clock_control.sv
// Purpose: self-checking bench for the clock control block
// Assumes: AXI4-Lite master tasks drive just after a rising clock edge
// Notes:   key writes keep bready high so the guarded write lands in time
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_clock_control
    import clock_control_pkg::*;
;
    int          mismatches = 0;      // failed comparisons
    int          compares   = 0;      // comparisons made
    int          cycles     = 0;      // clock cycles since start
    logic        clk = 0, rstn = 0;   // core clock and reset
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, xreq = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         xstrobe, xdone;      // transfer strobe and completion
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [2:0]  ticks;               // timer 2..0 count enables

    clock_control i_clock_control (
        .i_mclk(clk), .i_rstn(rstn),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .o_timer0_tick(ticks[0]),
        .o_timer1_tick(ticks[1]), .o_timer2_tick(ticks[2]),
        .i_xfer_req(xreq), .o_xfer_strobe(xstrobe), .o_xfer_done(xdone)
    );

    // free-running core clock, 20 ns period
    always #10 clk = ~clk;

    // hang guard: the whole run needs a few thousand cycles at most
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("[FAIL] timeout exp 0 got 1");
            test_done;
        end
    end

    // verdict and end of run
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one write; fast skips the lead edge, keep leaves bready high so the
    // next write can start at the handshake edge without a reassignment
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input bit fast, input bit keep,
                      output logic [1:0] r);
        int n;
        r = 2'bxx;
        if (!fast) @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                if (!keep) bready <= 1'b0;
                break;
            end
        end
    endtask

    // one read, address and rready held until the answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        d = 32'hx;
        r = 2'bxx;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // read a register and compare word and response
    task automatic reg_is(input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        `CHK("rdata", ex, d)
        `CHK("rresp", RESP_OKAY, r)
    endtask

    // plain write expecting OKAY
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, 1'b0, 1'b0, r);
        `CHK("bresp", RESP_OKAY, r)
    endtask

    // two keys then the guarded write, each started at the prior handshake
    task automatic unlock_put(input logic [7:0] d);
        logic [1:0] r;
        wr(TA_OFS, TA_KEY1, 1'b0, 1'b1, r);
        wr(TA_OFS, TA_KEY2, 1'b1, 1'b1, r);
        wr(CC_OFS, d, 1'b1, 1'b0, r);
        `CHK("bresp", RESP_OKAY, r)
    endtask

    // period of each timer tick; the first gap after a change is skipped
    task automatic gaps(input int e2, input int e1, input int e0);
        int ex [3];
        int k, n, g;
        ex = '{e0, e1, e2};
        for (k = 0; k < 3; k++) begin
            repeat (2) begin
                n = 0;
                do begin @(posedge clk); n++; end
                while (!ticks[k] && n < 40);
            end
            g = 0;
            do begin @(posedge clk); g++; end
            while (!ticks[k] && g < 40);
            `CHK("tick_gap", ex[k], g)
        end
    endtask

    // one transfer: count strobe cycles, done must follow at once
    task automatic xfer(input int el);
        int n;
        @(posedge clk);
        xreq <= 1'b1;
        @(posedge clk);
        xreq <= 1'b0;
        n = 0;
        do begin @(posedge clk); if (xstrobe) n++; end
        while (xstrobe && n < 60);
        `CHK("strobe_len", el, n)
        `CHK("xfer_done", 1'b1, xdone)
    endtask

    task automatic test_reset_values;
        reg_is(CC_OFS, 32'h39);
        gaps(12, 12, 12);
        xfer(12);
    endtask

    // write without unlock is ignored and flagged
    task automatic test_locked_write;
        logic [31:0] d;
        logic [1:0]  r;
        put(CC_OFS, 8'h00);
        reg_is(CC_OFS, 32'h39);
        rd(STAT_OFS, d, r);
        `CHK("refused", 1'b1, d[ST_REFUSED_BIT])
        put(STAT_OFS, 8'h04);
        rd(STAT_OFS, d, r);
        `CHK("refused", 1'b0, d[ST_REFUSED_BIT])
        // a foreign write between the keys spoils the unlock; the late
        // write would still fall inside a window, so a leak shows up
        put(TA_OFS, TA_KEY1);
        put(OPT_OFS, 8'h00);
        put(TA_OFS, TA_KEY2);
        put(CC_OFS, 8'h00);
        reg_is(CC_OFS, 32'h39);
    endtask

    // reserved bits stay zero; a later plain write leaves the register unchanged
    task automatic test_reserved;
        unlock_put(8'hFF);
        reg_is(CC_OFS, 32'h39);
        unlock_put(8'hC6);
        reg_is(CC_OFS, 32'h00);
        put(CC_OFS, 8'h28);
        reg_is(CC_OFS, 32'h00);
    endtask

    // every select value per timer, both stretch settings
    task automatic test_timebase;
        gaps(6, 6, 6);
        xfer(6);
        unlock_put(8'h11);
        gaps(6, 12, 6);
        xfer(12);
        unlock_put(8'h28);
        gaps(12, 6, 12);
    endtask

    // twelve-clock option overrides every select
    task automatic test_option;
        put(OPT_OFS, 8'h01);
        gaps(12, 12, 12);
        unlock_put(8'h01);
        gaps(12, 12, 12);
        xfer(24);
        put(OPT_OFS, 8'h00);
        gaps(6, 6, 6);
    endtask

    // unmapped address answers with an error, reads zero
    task automatic test_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        wr(8'h40, 8'hFF, 1'b0, 1'b0, r);
        `CHK("bresp", RESP_SLVERR, r)
        rd(8'h40, d, r);
        `CHK("rresp", RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        reg_is(CC_OFS, 32'h01);
    endtask

    // reset held two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        test_reset_values;
        test_locked_write;
        test_reserved;
        test_timebase;
        test_option;
        test_unmapped;
        test_done;
    end

endmodule // tb_clock_control
